// ==== src/rbc_pkg.sv ====
// Purpose: Constants and types for the RAM bank configuration block.
// Assumes: 32-bit register port with byte addresses.
// Notes:   Field positions follow the memory layout configuration word.
package rbc_pkg;
   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam logic [31:0] POWER_DOWN_ADDR = 32'h01f8_0008;
   localparam logic [31:0] MEM_CONFIG_ADDR = 32'h01f8_0010;
   // ****************************************************************
   // Configuration word layout
   // ****************************************************************
   localparam int CFG_WIDTH = 17;
   typedef struct packed {
      logic       boot_rom_write_enable;  // 16
      logic       reserved15;             // 15
      logic       ram_edac_enable;        // 14
      logic       ram_parity_enable;      // 13
      logic [2:0] ram_size_code;          // 12:10
      logic [2:0] spare_block1_target;    // 9:7
      logic       spare_block1_enable;    // 6
      logic [2:0] spare_block0_target;    // 5:3
      logic       spare_block0_enable;    // 2
      logic [1:0] ram_block_count;        // 1:0
   } rbc_config_t;
   localparam rbc_config_t CONFIG_RESET = 17'h1_0000;
   // ****************************************************************
   // RAM decode
   // ****************************************************************
   localparam int RAM_ADDR_WIDTH = 28;
   localparam int BLOCK_BASE_SHIFT = 18;   // 256 Kbyte per block at code 0
   localparam int RAM_BLOCKS = 8;
   localparam int CS_WIDTH = 10;
   localparam int SPARE0_CS = 8;
   localparam int SPARE1_CS = 9;
   localparam logic [CS_WIDTH-1:0] CS_IDLE = 10'h3ff;
endpackage

// ==== src/rbc_ram_bank_config.sv ====
// Purpose: RAM bank configuration register, chip-select decode with
//          spare-block substitution, protection enables, power-down.
// Assumes: Inputs synchronous to clock_i; chip selects active low.
// Notes:   All outputs are registered, so decode adds one cycle.
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
module rbc_ram_bank_config (
   // Clock and reset
   input  wire logic                              clock_i,
   input  wire logic                              reset_i,
   // Register port
   input  wire logic [31:0]                       addr_i,
   input  wire logic [31:0]                       wdata_i,
   input  wire logic                              wr_i,
   input  wire logic                              rd_i,
   output logic      [31:0]                       rdata_o,
   // System control
   input  wire logic                              power_down_enable_i,
   input  wire logic                              wakeup_i,
   output logic                                   power_down_o,
   // RAM access
   input  wire logic                              ram_access_i,
   input  wire logic [rbc_pkg::RAM_ADDR_WIDTH-1:0] ram_addr_i,
   output logic      [rbc_pkg::CS_WIDTH-1:0]      ram_chip_select_n_o,
   // Protection
   input  wire logic                              parity_check_disable_n_i,
   output logic                                   parity_check_o,
   output logic                                   parity_generate_o,
   output logic                                   edac_enable_o,
   // Boot memory write
   input  wire logic                              boot_rom_write_strobe_n_i,
   output logic                                   boot_rom_write_n_o
);
   // ****************************************************************
   // Register decode
   // ****************************************************************
   rbc_pkg::rbc_config_t cfg_reg;
   rbc_pkg::rbc_config_t cfg_next;
   logic                 pd_reg;
   logic [31:0]          rdata_reg;
   logic [rbc_pkg::CS_WIDTH-1:0] cs_n_reg;
   logic                 par_chk_reg;
   logic                 par_gen_reg;
   logic                 edac_reg;
   logic                 rom_wr_n_reg;

   wire logic hit_pd  = (addr_i == rbc_pkg::POWER_DOWN_ADDR);
   wire logic hit_cfg = (addr_i == rbc_pkg::MEM_CONFIG_ADDR);
   wire logic wr_cfg  = wr_i && hit_cfg;
   wire logic pd_trig = wr_i && hit_pd && power_down_enable_i;

   // Reserved bit is forced low so it can never be written.
   always_comb begin
      cfg_next = wdata_i[rbc_pkg::CFG_WIDTH-1:0];
      cfg_next.reserved15 = 1'b0;
   end

   // Power-down register reads as zero, as does any unmapped address.
   wire logic [31:0] rd_value = hit_cfg ?
      {{(32-rbc_pkg::CFG_WIDTH){1'b0}}, cfg_reg} : 32'h0000_0000;

   // ****************************************************************
   // Chip-select decode
   // ****************************************************************
   wire logic [rbc_pkg::RAM_ADDR_WIDTH-1:0] shifted =
      ram_addr_i >> (rbc_pkg::BLOCK_BASE_SHIFT + int'(cfg_reg.ram_size_code));
   wire logic [2:0] block_idx = shifted[2:0];
   // Addresses above the top block or beyond the enabled blocks select none.
   wire logic above_top = (shifted >> 3) != '0;
   wire logic in_range  = ((block_idx >> cfg_reg.ram_block_count) == 3'd0)
                          && !above_top;
   wire logic use_sp0 = cfg_reg.spare_block0_enable &&
                        (block_idx == cfg_reg.spare_block0_target);
   wire logic sp1_valid = cfg_reg.spare_block1_enable &&
      !(cfg_reg.spare_block0_target == cfg_reg.spare_block1_target);
   wire logic use_sp1 = sp1_valid && !use_sp0 &&
                        (block_idx == cfg_reg.spare_block1_target);

   logic [rbc_pkg::CS_WIDTH-1:0] cs_n_next;
   always_comb begin
      cs_n_next = rbc_pkg::CS_IDLE;
      if (ram_access_i && in_range) begin
         if (use_sp0) begin
            cs_n_next[rbc_pkg::SPARE0_CS] = 1'b0;
         end else if (use_sp1) begin
            cs_n_next[rbc_pkg::SPARE1_CS] = 1'b0;
         end else begin
            cs_n_next[block_idx] = 1'b0;
         end
      end
   end

   // ****************************************************************
   // Protection and boot memory write
   // ****************************************************************
   wire logic par_on = cfg_reg.ram_parity_enable ||
                       cfg_reg.ram_edac_enable;
   wire logic par_chk_next = par_on && parity_check_disable_n_i;
   wire logic rom_wr_n_next = !(cfg_reg.boot_rom_write_enable &&
                                !boot_rom_write_strobe_n_i);

   // ****************************************************************
   // Registers
   // ****************************************************************
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         cfg_reg <= rbc_pkg::CONFIG_RESET;
      end else if (wr_cfg) begin
         cfg_reg <= cfg_next;
      end
   end

   // Trigger wins over a wakeup in the same cycle so no request is lost.
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         pd_reg <= 1'b0;
      end else if (pd_trig) begin
         pd_reg <= 1'b1;
      end else if (wakeup_i) begin
         pd_reg <= 1'b0;
      end
   end

   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         rdata_reg <= 32'h0000_0000;
      end else if (rd_i) begin
         rdata_reg <= rd_value;
      end else begin
         rdata_reg <= 32'h0000_0000;
      end
   end

   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         cs_n_reg     <= rbc_pkg::CS_IDLE;
         par_chk_reg  <= 1'b0;
         par_gen_reg  <= 1'b0;
         edac_reg     <= 1'b0;
         rom_wr_n_reg <= 1'b1;
      end else begin
         cs_n_reg     <= cs_n_next;
         par_chk_reg  <= par_chk_next;
         par_gen_reg  <= par_on;
         edac_reg     <= cfg_reg.ram_edac_enable;
         rom_wr_n_reg <= rom_wr_n_next;
      end
   end

   assign rdata_o             = rdata_reg;
   assign power_down_o        = pd_reg;
   assign ram_chip_select_n_o = cs_n_reg;
   assign parity_check_o      = par_chk_reg;
   assign parity_generate_o   = par_gen_reg;
   assign edac_enable_o       = edac_reg;
   assign boot_rom_write_n_o  = rom_wr_n_reg;
endmodule

// ==== verif/rbc_ram_bank_config_chk.sv ====
// Purpose: Port assertions for the RAM bank configuration block.
// Assumes: One clock; reset_i asynchronous, active high.
// Notes:   Bound to the design from the bench top file.
`timescale 1ns/1ps
module rbc_ram_bank_config_chk (
   // Clock, reset and register port
   input wire logic        clock_i,
   input wire logic        reset_i,
   input wire logic [31:0] addr_i,
   input wire logic        wr_i,
   input wire logic        rd_i,
   input wire logic [31:0] rdata_o,
   // Power down, decode and protection
   input wire logic        power_down_enable_i,
   input wire logic        power_down_o,
   input wire logic        ram_access_i,
   input wire logic [9:0]  ram_chip_select_n_o,
   input wire logic        parity_check_disable_n_i,
   input wire logic        parity_check_o,
   input wire logic        parity_generate_o,
   input wire logic        edac_enable_o,
   input wire logic        boot_rom_write_strobe_n_i,
   input wire logic        boot_rom_write_n_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (reset_i);
   // A trigger needs the enable, so a plain address match is not enough.
   wire pd_hit = wr_i && power_down_enable_i &&
                 addr_i == rbc_pkg::POWER_DOWN_ADDR;
   AST_PD_SET: assert property (pd_hit |=> power_down_o)
      else $error("power down not entered");
   AST_PD_QUIET: assert property (
      !power_down_o && !pd_hit |=> !power_down_o)
      else $error("power down without trigger");
   AST_CS_OFF: assert property (!ram_access_i |=> &ram_chip_select_n_o)
      else $error("select without access");
   AST_CS_ONE: assert property ($onehot0(~ram_chip_select_n_o))
      else $error("more than one select");
   AST_PARITY_CHECK_DISABLE_N: assert property (
      !parity_check_disable_n_i |=> !parity_check_o)
      else $error("parity checked while disabled");
   AST_EDAC_PAR: assert property (edac_enable_o |-> parity_generate_o)
      else $error("edac without parity");
   AST_PAR_CHK: assert property (parity_check_o |-> parity_generate_o)
      else $error("check without parity on");
   AST_ROM_OFF: assert property (
      boot_rom_write_strobe_n_i |=> boot_rom_write_n_o)
      else $error("boot write without strobe");
   AST_RD_RSV: assert property (
      rd_i |=> rdata_o[31:17] == 0 && !rdata_o[15])
      else $error("reserved bits read nonzero");
   cover property (pd_hit);
   cover property (!ram_chip_select_n_o[8]);
   cover property (!ram_chip_select_n_o[9]);
endmodule

// ==== verif/rbc_ram_banks.sv ====
// Purpose: RAM bank array seen from the chip-select pins.
// Assumes: Selects active low; index 31 means none, 30 a clash.
// Notes:   A clash is reported rather than hidden.
`timescale 1ns/1ps
module rbc_ram_banks (
   // Pins
   input  wire logic [9:0] cs_n_i,
   output logic      [4:0] bank_o
);
   always_comb begin
      bank_o = 5'h1f;
      for (int k = 0; k < 10; k++)
         if (!cs_n_i[k]) bank_o = (bank_o == 5'h1f) ? 5'(k) : 5'h1e;
   end
endmodule

// ==== verif/rbc_ram_bank_config_tb.sv ====
// Purpose: Self-checking bench for the RAM bank configuration block.
// Assumes: Outputs registered, one cycle after their inputs.
// Notes:   Random configurations exercise decode and protection.
`timescale 1ns/1ps
module rbc_ram_bank_config_tb;
   logic clock_i = 0, reset_i = 1, wr_i = 0, rd_i = 0, wakeup_i = 0;
   logic power_down_enable_i = 0, ram_access_i = 0;
   logic parity_check_disable_n_i = 1, boot_rom_write_strobe_n_i = 1;
   logic [31:0] addr_i = '0, wdata_i = '0, rdata_o;
   logic [27:0] ram_addr_i = '0;
   logic [9:0]  ram_chip_select_n_o;
   logic [4:0]  bank;
   logic power_down_o, parity_check_o, parity_generate_o;
   logic edac_enable_o, boot_rom_write_n_o;
   int failures = 0, compares = 0, m = 32'h0001_0000, sz, idx, e, i;
   localparam logic [31:0] CFG = 32'h01f8_0010, PD = 32'h01f8_0008;
   rbc_ram_bank_config dut (.clock_i, .reset_i, .addr_i, .wdata_i, .wr_i,
      .rd_i, .rdata_o, .power_down_enable_i, .wakeup_i, .power_down_o,
      .ram_access_i, .ram_addr_i, .ram_chip_select_n_o,
      .parity_check_disable_n_i, .parity_check_o, .parity_generate_o,
      .edac_enable_o, .boot_rom_write_strobe_n_i, .boot_rom_write_n_o);
   rbc_ram_banks banks (.cs_n_i(ram_chip_select_n_o), .bank_o(bank));
   task automatic chk(string n, logic [31:0] x, logic [31:0] g);
      compares++;
      if (g !== x) begin
         failures++;
         $display("Error %s expected %h seen %h", n, x, g);
      end
   endtask
   task automatic wr(logic [31:0] a, logic [31:0] d);
      @(posedge clock_i);
      wr_i <= 1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clock_i);
      wr_i <= 0;
      #1;
   endtask
   task automatic rd(logic [31:0] a, logic [31:0] x);
      @(posedge clock_i);
      rd_i <= 1;
      addr_i <= a;
      @(posedge clock_i);
      rd_i <= 0;
      #1 chk("rdata", x, rdata_o);
   endtask
   task report_and_stop;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial forever #10 clock_i = ~clock_i;
   // A hang is cut short here and counted as a mismatch.
   initial begin
      #2000000 failures++;
      report_and_stop;
   end
   initial begin
      i = $urandom(32'h1bcb1b32);
      repeat (8) @(posedge clock_i);
      reset_i <= 0;
      rd(CFG, m);
      rd(32'h01f8_000c, 0);
      wr(CFG, '1);
      rd(CFG, 32'h0001_7fff);
      wr(PD, '1);
      chk("power down", 0, power_down_o);
      rd(PD, 0);
      @(posedge clock_i) power_down_enable_i <= 1;
      wr(PD, 0);
      chk("power down", 1, power_down_o);
      @(posedge clock_i) wakeup_i <= 1;
      @(posedge clock_i) wakeup_i <= 0;
      #1 chk("power down", 0, power_down_o);
      $display("register and power down test done");
      for (i = 0; i < 400; i++) begin
         e = $urandom;
         wr(CFG, e);
         m = e & 32'h0001_7fff;
         sz = m[12:10];
         @(posedge clock_i);
         ram_addr_i <= 28'((($urandom % 9) << (18 + sz)) + $urandom % 999);
         ram_access_i <= ($urandom % 8) != 0;
         parity_check_disable_n_i <= 1'($urandom % 2);
         boot_rom_write_strobe_n_i <= 1'($urandom % 2);
         @(posedge clock_i);
         #1 idx = int'(ram_addr_i >> (18 + sz));
         e = (!ram_access_i || idx >= (1 << m[1:0])) ? 31 : idx;
         if (m[2] && e == m[5:3]) e = 8;
         else if (m[6] && e == m[9:7] && m[9:7] != m[5:3]) e = 9;
         chk("bank", e, bank);
         chk("par chk", (m[13] | m[14]) & parity_check_disable_n_i,
             parity_check_o);
         chk("par gen", m[13] | m[14], parity_generate_o);
         chk("edac", m[14], edac_enable_o);
         chk("rom wr", m[16] ? boot_rom_write_strobe_n_i : 1'b1,
             boot_rom_write_n_o);
      end
      $display("decode and protection test done");
      report_and_stop;
   end
endmodule
bind rbc_ram_bank_config rbc_ram_bank_config_chk chk (.clock_i, .reset_i,
   .addr_i, .wr_i, .rd_i, .rdata_o, .power_down_enable_i, .power_down_o,
   .ram_access_i, .ram_chip_select_n_o, .parity_check_disable_n_i,
   .parity_check_o, .parity_generate_o, .edac_enable_o,
   .boot_rom_write_strobe_n_i, .boot_rom_write_n_o);
